// ===== core/tci_pkg.sv
package tci_pkg;

    // command bytes on the link
    localparam logic [7:0] CMD_MATCH_ID       = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID        = 8'hcc;
    localparam logic [7:0] CMD_ALARM_SEARCH   = 8'hec;
    localparam logic [7:0] CMD_SEARCH         = 8'hf0;
    localparam logic [7:0] CMD_CONVERT        = 8'h44;
    localparam logic [7:0] CMD_WRITE_PAD      = 8'h4e;
    localparam logic [7:0] CMD_READ_PAD       = 8'hbe;
    localparam logic [7:0] CMD_COPY_PAD       = 8'h48;
    localparam logic [7:0] CMD_EEPROM_RECALL  = 8'hb8;
    localparam logic [7:0] CMD_READ_POWER     = 8'hb4;

    // scratchpad byte offsets
    localparam logic [3:0] SP_TEMP_LO         = 4'h0;
    localparam logic [3:0] SP_TEMP_HI         = 4'h1;
    localparam logic [3:0] SP_UPPER_ALARM     = 4'h2;
    localparam logic [3:0] SP_LOWER_ALARM     = 4'h3;
    localparam logic [3:0] SP_CONFIG          = 4'h4;
    localparam logic [3:0] SP_CHECK_BYTE      = 4'h8;

    // transfer lengths
    localparam logic [2:0] BIT_LAST           = 3'h7;
    localparam logic [3:0] ID_BYTE_LAST       = 4'h7;
    localparam logic [3:0] WR_BYTE_LAST       = 4'h2;
    localparam logic [3:0] SP_BYTE_LAST       = 4'h8;

    // configuration byte layout
    localparam int         CFG_RES_LSB        = 5;
    localparam logic [7:0] CFG_FIXED_ONES     = 8'h1f;
    localparam logic [7:0] CFG_RES_MASK       = 8'h60;
    localparam logic [7:0] CFG_RST            = 8'h7f;

    // values after reset, and the value read from reserved scratchpad bytes
    localparam logic [7:0]  UPPER_RST         = 8'h00;
    localparam logic [7:0]  LOWER_RST         = 8'h00;
    localparam logic [15:0] TEMP_RST          = 16'h0000;
    localparam logic [7:0]  SP_RESERVED_VAL   = 8'hff;

    // byte buffer
    localparam int         FIFO_WIDTH         = 8;
    localparam int         FIFO_DEPTH         = 8;

endpackage

// ===== core/tci_fifo.sv
`timescale 1ns/1ps
module tci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } tci_fifo_s;

    tci_fifo_s s_r;
    tci_fifo_s s_nxt;
    logic      push;
    logic      pop;

    assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_r.cnt != '0);
    assign o_out_data  = s_r.mem[s_r.rp];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = i_out_ready && o_out_valid;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = i_in_data;
            s_nxt.wp          = ptr_inc(s_r.wp);
        end
        if (pop) begin
            s_nxt.rp = ptr_inc(s_r.rp);
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush) begin
            s_nxt.wp  = '0;
            s_nxt.rp  = '0;
            s_nxt.cnt = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ===== core/tci_core.sv
`timescale 1ns/1ps
module tci_core (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_bus_reset,
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_bit,
    output logic             o_rx_ready,
    input  wire logic        i_read_slot,
    output logic             o_tx_bit,
    input  wire logic [63:0] i_rom_id,
    input  wire logic        i_parasite,
    input  wire logic [7:0]  i_sp_crc,
    output logic             o_search_start,
    output logic             o_search_alarm,
    output logic             o_conv_start,
    input  wire logic        i_conv_done,
    input  wire logic [15:0] i_conv_temp,
    output logic [1:0]       o_resolution,
    output logic             o_ee_write,
    output logic             o_ee_read,
    output logic [23:0]      o_ee_wdata,
    input  wire logic        i_ee_done,
    input  wire logic [23:0] i_ee_rdata,
    output logic [15:0]      o_temp,
    output logic [7:0]       o_upper,
    output logic [7:0]       o_lower,
    output logic [7:0]       o_config,
    output logic             o_alarm
);
    typedef enum logic [3:0] {
        ST_BOOT,
        ST_ROM,
        ST_MATCH,
        ST_FUNC,
        ST_WRITE,
        ST_READ,
        ST_CONV,
        ST_RECALL,
        ST_PWR,
        ST_IGNORE
    } tci_state_e;

    typedef struct packed {
        tci_state_e  state;
        logic        par_meta;
        logic        par_sync;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_cnt;
        logic        rx_full;
        logic        rx_ready;
        logic [3:0]  idx;
        logic [2:0]  bitn;
        logic        miss;
        logic        tx_bit;
        logic        conv_busy;
        logic        conv_start;
        logic        ee_busy;
        logic        ee_is_read;
        logic        ee_write;
        logic        ee_read;
        logic [23:0] ee_wdata;
        logic        search_start;
        logic        search_alarm;
        logic [15:0] temp;
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic [7:0]  config_b;
        logic        alarm;
    } tci_core_s;

    tci_core_s  s_r;
    tci_core_s  s_nxt;
    logic       f_valid;
    logic [7:0] f_data;
    logic       f_in_ready;
    logic       pop;

    // keeps the fixed configuration bits at their stuck values
    function automatic logic [7:0] cfg_fix(input logic [7:0] d);
        cfg_fix = (d & tci_pkg::CFG_RES_MASK) | tci_pkg::CFG_FIXED_ONES;
    endfunction

    function automatic logic [7:0] sp_byte(input tci_core_s s, input logic [3:0] i,
                                           input logic [7:0] crc);
        unique case (i)
            tci_pkg::SP_TEMP_LO:     sp_byte = s.temp[7:0];
            tci_pkg::SP_TEMP_HI:     sp_byte = s.temp[15:8];
            tci_pkg::SP_UPPER_ALARM: sp_byte = s.upper;
            tci_pkg::SP_LOWER_ALARM: sp_byte = s.lower;
            tci_pkg::SP_CONFIG:      sp_byte = s.config_b;
            tci_pkg::SP_CHECK_BYTE:  sp_byte = crc;
            default:                 sp_byte = tci_pkg::SP_RESERVED_VAL;
        endcase
    endfunction

    function automatic logic alarm_test(input logic [15:0] t, input logic [7:0] hi,
                                        input logic [7:0] lo);
        logic signed [7:0] whole;
        whole      = signed'(t[11:4]);
        alarm_test = (whole > signed'(hi)) || (whole < signed'(lo));
    endfunction

    tci_fifo #(
        .WIDTH (tci_pkg::FIFO_WIDTH),
        .DEPTH (tci_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_flush     (i_bus_reset),
        .i_in_valid  (s_r.rx_full),
        .o_in_ready  (f_in_ready),
        .i_in_data   (s_r.rx_sh),
        .o_out_valid (f_valid),
        .i_out_ready (pop),
        .o_out_data  (f_data)
    );

    always_comb begin
        logic [7:0] byte_v;
        byte_v         = 8'h00;
        s_nxt          = s_r;
        pop            = 1'b0;
        s_nxt.par_meta = i_parasite;
        s_nxt.par_sync = s_r.par_meta;
        s_nxt.conv_start   = 1'b0;
        s_nxt.ee_write     = 1'b0;
        s_nxt.ee_read      = 1'b0;
        s_nxt.search_start = 1'b0;

        // byte assembly, first bit lands in bit 0
        if (s_r.rx_full && f_in_ready) begin
            s_nxt.rx_full  = 1'b0;
            s_nxt.rx_ready = 1'b1;
        end
        if (i_rx_valid && s_r.rx_ready) begin
            s_nxt.rx_sh  = {i_rx_bit, s_r.rx_sh[7:1]};
            s_nxt.rx_cnt = s_r.rx_cnt + 3'h1;
            if (s_r.rx_cnt == tci_pkg::BIT_LAST) begin
                s_nxt.rx_full  = 1'b1;
                s_nxt.rx_ready = 1'b0;
            end
        end

        // completions are taken in any state so a reset cannot lose them
        if (s_r.conv_busy && i_conv_done) begin
            s_nxt.conv_busy = 1'b0;
            s_nxt.temp      = i_conv_temp;
            s_nxt.alarm     = alarm_test(i_conv_temp, s_r.upper, s_r.lower);
        end
        if (s_r.ee_busy && i_ee_done) begin
            s_nxt.ee_busy = 1'b0;
            if (s_r.ee_is_read) begin
                s_nxt.upper    = i_ee_rdata[7:0];
                s_nxt.lower    = i_ee_rdata[15:8];
                s_nxt.config_b = cfg_fix(i_ee_rdata[23:16]);
            end
        end

        unique case (s_r.state)
            ST_BOOT: begin
                s_nxt.ee_read    = 1'b1;
                s_nxt.ee_busy    = 1'b1;
                s_nxt.ee_is_read = 1'b1;
                s_nxt.state      = ST_IGNORE;
            end
            ST_ROM: begin
                pop = f_valid;
                if (f_valid) begin
                    s_nxt.idx  = 4'h0;
                    s_nxt.miss = 1'b0;
                    unique case (f_data)
                        tci_pkg::CMD_MATCH_ID: s_nxt.state = ST_MATCH;
                        tci_pkg::CMD_SKIP_ID:  s_nxt.state = ST_FUNC;
                        tci_pkg::CMD_ALARM_SEARCH: begin
                            s_nxt.search_start = s_r.alarm;
                            s_nxt.search_alarm = 1'b1;
                            s_nxt.state        = ST_IGNORE;
                        end
                        tci_pkg::CMD_SEARCH: begin
                            s_nxt.search_start = 1'b1;
                            s_nxt.search_alarm = 1'b0;
                            s_nxt.state        = ST_IGNORE;
                        end
                        default: s_nxt.state = ST_IGNORE;
                    endcase
                end
            end
            ST_MATCH: begin
                pop = f_valid;
                if (f_valid) begin
                    byte_v = i_rom_id[s_r.idx[2:0]*8 +: 8];
                    if (f_data != byte_v) begin
                        s_nxt.miss = 1'b1;
                    end
                    s_nxt.idx = s_r.idx + 4'h1;
                    if (s_r.idx == tci_pkg::ID_BYTE_LAST) begin
                        s_nxt.state = (s_r.miss || (f_data != byte_v)) ? ST_IGNORE
                                                                       : ST_FUNC;
                    end
                end
            end
            ST_FUNC: begin
                // hold the byte back until the previous long operation is over
                pop = f_valid && !s_r.conv_busy && !s_r.ee_busy;
                if (pop) begin
                    s_nxt.idx  = 4'h0;
                    s_nxt.bitn = 3'h0;
                    unique case (f_data)
                        tci_pkg::CMD_CONVERT: begin
                            s_nxt.conv_start = 1'b1;
                            s_nxt.conv_busy  = 1'b1;
                            s_nxt.state      = ST_CONV;
                        end
                        tci_pkg::CMD_WRITE_PAD: s_nxt.state = ST_WRITE;
                        tci_pkg::CMD_READ_PAD:  s_nxt.state = ST_READ;
                        tci_pkg::CMD_COPY_PAD: begin
                            s_nxt.ee_write   = 1'b1;
                            s_nxt.ee_busy    = 1'b1;
                            s_nxt.ee_is_read = 1'b0;
                            s_nxt.ee_wdata   = {s_r.config_b, s_r.lower, s_r.upper};
                            s_nxt.state      = ST_IGNORE;
                        end
                        tci_pkg::CMD_EEPROM_RECALL: begin
                            s_nxt.ee_read    = 1'b1;
                            s_nxt.ee_busy    = 1'b1;
                            s_nxt.ee_is_read = 1'b1;
                            s_nxt.state      = ST_RECALL;
                        end
                        tci_pkg::CMD_READ_POWER: s_nxt.state = ST_PWR;
                        default:                 s_nxt.state = ST_IGNORE;
                    endcase
                end
            end
            ST_WRITE: begin
                pop = f_valid;
                if (f_valid) begin
                    s_nxt.idx = s_r.idx + 4'h1;
                    unique case (s_r.idx)
                        4'h0:    s_nxt.upper    = f_data;
                        4'h1:    s_nxt.lower    = f_data;
                        default: s_nxt.config_b = cfg_fix(f_data);
                    endcase
                    if (s_r.idx == tci_pkg::WR_BYTE_LAST) begin
                        s_nxt.state = ST_IGNORE;
                    end
                end
            end
            ST_READ: begin
                pop = f_valid;
                if (i_read_slot) begin
                    s_nxt.bitn = s_r.bitn + 3'h1;
                    if (s_r.bitn == tci_pkg::BIT_LAST) begin
                        s_nxt.idx = s_r.idx + 4'h1;
                        if (s_r.idx == tci_pkg::SP_BYTE_LAST) begin
                            s_nxt.state = ST_IGNORE;
                        end
                    end
                end
            end
            ST_CONV, ST_RECALL: begin
                pop = f_valid;
            end
            ST_PWR: begin
                pop = f_valid;
                if (i_read_slot) begin
                    s_nxt.state = ST_IGNORE;
                end
            end
            ST_IGNORE: begin
                pop = f_valid;
            end
        endcase

        if (i_bus_reset) begin
            pop            = 1'b0;
            s_nxt.rx_cnt   = 3'h0;
            s_nxt.rx_full  = 1'b0;
            s_nxt.rx_ready = 1'b1;
            if (s_r.state != ST_BOOT) begin
                s_nxt.state = ST_ROM;
            end
        end

        // answer for the next read slot, 1 leaves the line released
        unique case (s_nxt.state)
            ST_READ: begin
                byte_v       = sp_byte(s_nxt, s_nxt.idx, i_sp_crc);
                s_nxt.tx_bit = byte_v[s_nxt.bitn];
            end
            ST_CONV:   s_nxt.tx_bit = s_r.par_sync || !s_nxt.conv_busy;
            ST_RECALL: s_nxt.tx_bit = !s_nxt.ee_busy;
            ST_PWR:    s_nxt.tx_bit = !s_r.par_sync;
            default:   s_nxt.tx_bit = 1'b1;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s_r          <= '0;
            s_r.state    <= ST_BOOT;
            s_r.rx_ready <= 1'b1;
            s_r.tx_bit   <= 1'b1;
            s_r.temp     <= tci_pkg::TEMP_RST;
            s_r.upper    <= tci_pkg::UPPER_RST;
            s_r.lower    <= tci_pkg::LOWER_RST;
            s_r.config_b <= tci_pkg::CFG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rx_ready     = s_r.rx_ready;
    assign o_tx_bit       = s_r.tx_bit;
    assign o_search_start = s_r.search_start;
    assign o_search_alarm = s_r.search_alarm;
    assign o_conv_start   = s_r.conv_start;
    assign o_resolution   = s_r.config_b[tci_pkg::CFG_RES_LSB +: 2];
    assign o_ee_write     = s_r.ee_write;
    assign o_ee_read      = s_r.ee_read;
    assign o_ee_wdata     = s_r.ee_wdata;
    assign o_temp         = s_r.temp;
    assign o_upper        = s_r.upper;
    assign o_lower        = s_r.lower;
    assign o_config       = s_r.config_b;
    assign o_alarm        = s_r.alarm;
endmodule

// ===== sim/tci_core_sva.sv
`timescale 1ns/1ps
module tci_core_sva (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_bus_reset,
    input wire logic        i_rx_valid,
    input wire logic        o_rx_ready,
    input wire logic        o_tx_bit,
    input wire logic        o_conv_start,
    input wire logic        i_conv_done,
    input wire logic [15:0] i_conv_temp,
    input wire logic [1:0]  o_resolution,
    input wire logic        o_ee_write,
    input wire logic        o_ee_read,
    input wire logic [23:0] o_ee_wdata,
    input wire logic        i_ee_done,
    input wire logic [23:0] i_ee_rdata,
    input wire logic [15:0] o_temp,
    input wire logic [7:0]  o_upper,
    input wire logic [7:0]  o_lower,
    input wire logic [7:0]  o_config,
    input wire logic        o_search_start,
    input wire logic        o_search_alarm,
    input wire logic        o_alarm
);
    logic [2:0] bcnt_r;
    logic       pend_r;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // bit position within the byte and an open recall
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_bus_reset) bcnt_r <= 3'h0;
        else if (i_rx_valid && o_rx_ready) bcnt_r <= bcnt_r + 3'h1;
        if (!i_rst_n || i_ee_done) pend_r <= 1'b0;
        else if (o_ee_read) pend_r <= 1'b1;
    end
    sequence last_bit_s;
        i_rx_valid && o_rx_ready && bcnt_r == 3'h7;
    endsequence
    sequence recall_end_s;
        pend_r && i_ee_done;
    endsequence
    rst_values_a: assert property (disable iff (1'b0) !i_rst_n |=> o_tx_bit && o_rx_ready
        && !o_alarm && o_config == 8'h7f && o_temp == 16'h0000) else $error("reset values wrong");
    pwrup_recall_a: assert property ($rose(i_rst_n) |-> ##[0:2] o_ee_read)
        else $error("no recall after reset");
    cfg_fixed_a: assert property (!o_config[7] && o_config[4:0] == 5'h1f
        && o_resolution == o_config[6:5]) else $error("config fixed bits wrong");
    copy_data_a: assert property (o_ee_write |-> o_ee_wdata == {o_config, o_lower, o_upper})
        else $error("copy data wrong");
    recall_load_a: assert property (recall_end_s |=> o_upper == $past(i_ee_rdata[7:0])
        && o_lower == $past(i_ee_rdata[15:8])
        && o_config == (($past(i_ee_rdata[23:16]) & 8'h60) | 8'h1f)) else $error("recall load wrong");
    conv_store_a: assert property (i_conv_done |=> o_temp == $past(i_conv_temp))
        else $error("temperature not stored");
    alarm_cmp_a: assert property (i_conv_done |=> o_alarm ==
        ($signed($past(i_conv_temp[11:4])) > $signed($past(o_upper))
        || $signed($past(i_conv_temp[11:4])) < $signed($past(o_lower)))) else $error("alarm flag wrong");
    byte_end_a: assert property (last_bit_s |=> !o_rx_ready) else $error("no stall at byte end");
    alarm_search_a: assert property (o_search_start && o_search_alarm |-> o_alarm)
        else $error("alarm search while clear");
    conv_pulse_a: assert property (o_conv_start |=> !o_conv_start) else $error("convert not a pulse");
endmodule
bind tci_core tci_core_sva u_sva (.i_mclk, .i_rst_n, .i_bus_reset, .i_rx_valid, .o_rx_ready,
    .o_tx_bit, .o_conv_start, .i_conv_done, .i_conv_temp, .o_resolution, .o_ee_write, .o_ee_read,
    .o_ee_wdata, .i_ee_done, .i_ee_rdata, .o_temp, .o_upper, .o_lower, .o_config,
    .o_search_start, .o_search_alarm, .o_alarm);

// ===== sim/tci_master.sv
`timescale 1ns/1ps
module tci_master (
    input  wire logic i_mclk,
    input  wire logic i_rx_ready,
    input  wire logic i_tx_bit,
    output logic      o_bus_reset,
    output logic      o_rx_valid,
    output logic      o_rx_bit,
    output logic      o_read_slot,
    output logic      o_hang
);
    initial begin
        {o_bus_reset, o_rx_valid, o_rx_bit, o_read_slot, o_hang} = 5'h00;
    end
    task automatic bus_rst();
        @(negedge i_mclk) o_bus_reset = 1'b1;
        @(negedge i_mclk) o_bus_reset = 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic send(input logic [7:0] b);
        int w;
        for (int k = 0; k < 8; k++) begin
            @(negedge i_mclk);
            o_rx_valid = 1'b1;
            o_rx_bit   = b[k];
            w = 0;
            do begin
                @(posedge i_mclk);
                w++;
            end while (!i_rx_ready && w < 400);
            if (!i_rx_ready) o_hang = 1'b1;
        end
        @(negedge i_mclk);
        o_rx_valid = 1'b0;
        o_rx_bit   = ~o_rx_bit;
    endtask
    // slots are spaced; the device bit is taken at the edge that sees the slot
    task automatic rd(input int n, output logic [71:0] d);
        d = '0;
        for (int k = 0; k < n; k++) begin
            repeat (3) @(negedge i_mclk);
            o_read_slot = 1'b1;
            @(posedge i_mclk) d[k] = i_tx_bit;
            @(negedge i_mclk) o_read_slot = 1'b0;
        end
    endtask
endmodule

// ===== sim/thermometer_command_interpreter_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module thermometer_command_interpreter_tb;
    logic        i_mclk = 0, i_rst_n = 0, i_parasite = 0, i_conv_done = 0, i_ee_done = 0;
    logic [15:0] i_conv_temp = 16'h0000;
    logic [23:0] i_ee_rdata  = 24'h000000, ee_mem = 24'h3ff632;
    logic [63:0] id          = 64'h1122334455667788;
    logic [7:0]  sp_crc      = 8'h5a;
    logic        bus_rst, rx_valid, rx_bit, slot, hang, rx_ready, tx_bit, s_start, s_alarm;
    logic        conv_start, ee_write, ee_read, alarm, last_sa;
    logic [1:0]  res;
    logic [23:0] ee_wdata;
    logic [15:0] temp;
    logic [7:0]  upper, lower, cfg;
    logic [71:0] d;
    int          n_fail = 0, total_checks = 0, n_conv = 0, n_srch = 0, ee_cnt = 0;
    always #20 i_mclk = ~i_mclk;
    tci_core DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_reset(bus_rst), .i_rx_valid(rx_valid),
        .i_rx_bit(rx_bit), .o_rx_ready(rx_ready), .i_read_slot(slot), .o_tx_bit(tx_bit),
        .i_rom_id(id), .i_parasite(i_parasite), .i_sp_crc(sp_crc), .o_search_start(s_start),
        .o_search_alarm(s_alarm), .o_conv_start(conv_start), .i_conv_done(i_conv_done),
        .i_conv_temp(i_conv_temp), .o_resolution(res), .o_ee_write(ee_write), .o_ee_read(ee_read),
        .o_ee_wdata(ee_wdata), .i_ee_done(i_ee_done), .i_ee_rdata(i_ee_rdata), .o_temp(temp),
        .o_upper(upper), .o_lower(lower), .o_config(cfg), .o_alarm(alarm));
    tci_master M (.i_mclk(i_mclk), .i_rx_ready(rx_ready), .i_tx_bit(tx_bit), .o_bus_reset(bus_rst),
        .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .o_read_slot(slot), .o_hang(hang));
    // eeprom with a 20 cycle access, event counters
    always @(negedge i_mclk) begin
        i_ee_done <= 1'b0;
        if (ee_write) ee_mem <= ee_wdata;
        if (ee_write || ee_read) ee_cnt <= 20;
        else if (ee_cnt == 1) begin
            i_ee_done  <= 1'b1;
            i_ee_rdata <= ee_mem;
            ee_cnt     <= 0;
        end else if (ee_cnt != 0) ee_cnt <= ee_cnt - 1;
        if (conv_start) n_conv++;
        if (s_start) begin
            n_srch++;
            last_sa = s_alarm;
        end
    end
    always @(posedge hang) begin
        n_fail++;
        print_verdict();
    end
    task automatic print_verdict();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic sel(input bit skip);
        M.bus_rst();
        if (skip) M.send(8'hcc);
        else begin
            M.send(8'h55);
            for (int k = 0; k < 8; k++) M.send(id[8*k+:8]);
        end
    endtask
    task automatic t_powerup();
        repeat (30) @(negedge i_mclk);
        `CHK("upper", 8'h32, upper)
        `CHK("lower", 8'hf6, lower)
        `CHK("config", 8'h3f, cfg)
        $display("test powerup done");
    endtask
    task automatic t_write();
        sel(1);
        M.send(8'h4e);
        M.send(8'h14);
        M.send(8'h05);
        M.send(8'hc0);
        repeat (8) @(negedge i_mclk);
        `CHK("upper", 8'h14, upper)
        `CHK("lower", 8'h05, lower)
        `CHK("config", 8'h5f, cfg)
        `CHK("resolution", 2'b10, res)
        $display("test write done");
    endtask
    task automatic t_convert();
        sel(0);
        M.send(8'h44);
        M.rd(1, d);
        `CHK("busy slot", 1'b0, d[0])
        `CHK("conversions", 1, n_conv)
        // a new function byte waits in the buffer while the conversion runs
        sel(1);
        for (int k = 0; k < 9; k++) M.send(k == 0 ? 8'h44 : 8'h00);
        repeat (4) @(negedge i_mclk);
        `CHK("buffer full", 1'b0, rx_ready)
        `CHK("held command", 1, n_conv)
        for (int k = 0; k < 2; k++) begin
            @(negedge i_mclk);
            i_conv_temp = k ? 16'h0190 : 16'h0050;
            i_conv_done = 1'b1;
            @(negedge i_mclk) i_conv_done = 1'b0;
            M.rd(1, d);
            `CHK("conv slot", k[0], d[0])
            `CHK("temp", k ? 16'h0190 : 16'h0050, temp)
            `CHK("alarm", k[0], alarm)
            `CHK("conversions", 2, n_conv)
        end
        `CHK("drained", 1'b1, rx_ready)
        $display("test convert done");
    endtask
    task automatic t_read();
        sel(1);
        M.send(8'hbe);
        M.rd(12, d);
        `CHK("partial read", 12'h190, d[11:0])
        sp_crc = 8'ha5;
        sel(1);
        M.send(8'hbe);
        M.rd(72, d);
        `CHK("scratchpad", {8'ha5, 24'hffffff, 8'h5f, 8'h05, 8'h14, 16'h0190}, d)
        $display("test read done");
    endtask
    task automatic t_ignore();
        M.bus_rst();
        M.send(8'h55);
        for (int k = 0; k < 8; k++) M.send(id[8*k+:8] ^ {7'h00, k == 7});
        M.send(8'h44);
        M.bus_rst();
        M.send(8'h33);
        M.send(8'h44);
        M.rd(1, d);
        `CHK("unknown slot", 1'b1, d[0])
        M.bus_rst();
        M.send(8'h44);
        M.send(8'h44);
        repeat (4) @(negedge i_mclk);
        `CHK("conversions", 2, n_conv)
        $display("test ignore done");
    endtask
    task automatic t_search();
        M.bus_rst();
        M.send(8'hec);
        repeat (4) @(negedge i_mclk);
        `CHK("searches", 1, n_srch)
        `CHK("alarm search", 1'b1, last_sa)
        M.bus_rst();
        M.send(8'hf0);
        repeat (4) @(negedge i_mclk);
        `CHK("searches", 2, n_srch)
        `CHK("plain search", 1'b0, last_sa)
        $display("test search done");
    endtask
    task automatic t_copy();
        sel(1);
        M.send(8'h48);
        repeat (30) @(negedge i_mclk);
        `CHK("eeprom", 24'h5f0514, ee_mem)
        sel(1);
        M.send(8'h4e);
        for (int k = 0; k < 3; k++) M.send(8'h00);
        sel(1);
        M.send(8'hb8);
        M.rd(1, d);
        `CHK("recall busy", 1'b0, d[0])
        repeat (30) @(negedge i_mclk);
        M.rd(1, d);
        `CHK("recall done", 1'b1, d[0])
        `CHK("upper", 8'h14, upper)
        `CHK("config", 8'h5f, cfg)
        $display("test copy done");
    endtask
    task automatic t_power();
        id = 64'h0f1e2d3c4b5a6978;
        for (int p = 0; p < 2; p++) begin
            i_parasite = p[0];
            sel(!p[0]);
            M.send(8'hb4);
            M.rd(1, d);
            `CHK("power slot", ~p[0], d[0])
        end
        // parasite conversion: the line stays quiet under the strong pullup
        sel(1);
        M.send(8'h44);
        repeat (30) @(negedge i_mclk);
        `CHK("parasite busy bit", 1'b1, tx_bit)
        `CHK("conversions", 3, n_conv)
        i_conv_done = 1'b1;
        @(negedge i_mclk) i_conv_done = 1'b0;
        $display("test power done");
    endtask
    initial begin
        repeat (10) @(negedge i_mclk);
        i_rst_n = 1'b1;
        t_powerup();
        t_write();
        t_convert();
        t_read();
        t_ignore();
        t_search();
        t_copy();
        t_power();
        print_verdict();
    end
endmodule
